//--- rcr_pkg.sv
package rcr_pkg;
  // register byte addresses
  localparam logic [31:0] CAL_DATE_WORD_ADDR = 32'hfffffebc;
  localparam logic [31:0] CAL_STATUS_ADDR = 32'hfffffec0;
  localparam logic [31:0] CAL_CTRL_ADDR = 32'hfffffec4;

  // field positions inside the date word
  localparam int CENTURY_FIELD_LSB = 0;
  localparam int CENTURY_FIELD_W = 7;
  localparam int YEAR_LSB = 8;
  localparam int YEAR_W = 8;
  localparam int MONTH_LSB = 16;
  localparam int MONTH_W = 5;
  localparam int DOW_LSB = 21;
  localparam int DOW_W = 3;
  localparam int DATE_LSB = 24;
  localparam int DATE_W = 6;

  // legal ranges, bcd coded
  localparam logic [6:0] CENTURY_FIELD_ONLY = 7'h20;
  localparam logic [7:0] YEAR_MIN = 8'h00;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [4:0] MONTH_MIN = 5'h01;
  localparam logic [4:0] MONTH_MAX = 5'h12;
  localparam logic [2:0] DOW_MIN = 3'h1;
  localparam logic [2:0] DOW_MAX = 3'h7;
  localparam logic [5:0] DATE_MIN = 6'h01;
  localparam logic [5:0] DATE_MAX = 6'h31;

  // month lengths, bcd coded
  localparam logic [5:0] LEN_LONG = 6'h31;
  localparam logic [5:0] LEN_SHORT = 6'h30;
  localparam logic [5:0] LEN_FEB = 6'h28;
  localparam logic [5:0] LEN_FEB_LEAP = 6'h29;

  // reset values of the fields
  localparam logic [6:0] CENTURY_FIELD_RST = 7'h20;
  localparam logic [7:0] YEAR_RST = 8'h00;
  localparam logic [4:0] MONTH_RST = 5'h01;
  localparam logic [2:0] DOW_RST = 3'h1;
  localparam logic [5:0] DATE_RST = 6'h01;

  // status and control bits
  localparam int STAT_BAD_WRITE_BIT = 0;
  localparam int STAT_YEAR_WRAP_BIT = 1;
  localparam int CTRL_COUNT_EN_BIT = 0;
  localparam logic CTRL_COUNT_EN_RST = 1'b1;
endpackage

//--- rcr_bcd_check.sv
// checks a bcd value: units digit legal and value inside [LO, HI]
module rcr_bcd_check #(
  parameter int W = 8,
  parameter logic [W-1:0] LO = '0,
  parameter logic [W-1:0] HI = '1
) (
  input wire logic [W-1:0] value,
  output logic ok
);
  logic unitsOk;

  assign unitsOk = (value[3:0] <= 4'h9);
  assign ok = unitsOk && (value >= LO) && (value <= HI);
endmodule

//--- rcr_bcd_inc.sv
// bcd increment; past the limit the value wraps to LO
module rcr_bcd_inc #(
  parameter int W = 8,
  parameter logic [W-1:0] LO = '0
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] nextValue,
  output logic wrap
);
  logic [W-1:0] bumped;

  always_comb begin
    bumped = value;
    if (value[3:0] >= 4'h9) begin
      bumped[3:0] = 4'h0;
      bumped[W-1:4] = value[W-1:4] + (W-4)'(1);
    end else begin
      bumped[3:0] = value[3:0] + 4'h1;
    end
  end

  assign wrap = (value >= limit);
  assign nextValue = wrap ? LO : bumped;
endmodule

//--- rcr_calendar_register.sv
// Notes on behaviour
// - century accepts only bcd twenty
// - year holds bcd 00 through 99
// - month holds bcd 01 through 12
// - day of month holds bcd 01 through 31
// - day of week 1-7, no date effect
// - low nibble units, upper bits tens
//
// Local design decision: strobed register access.
module rcr_calendar_register (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [31:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [31:0] rdData,
  input wire logic dayTick,
  output logic [31:0] dateWord
);
  logic [6:0] century_field_q;
  logic [7:0] year_q;
  logic [4:0] month_q;
  logic [2:0] dow_q;
  logic [5:0] date_q;
  logic badWrite_q;
  logic yearWrap_q;
  logic countEn_q;
  logic [31:0] rdData_q;

  logic selDate;
  logic selStat;
  logic selCtrl;
  logic [6:0] wCent;
  logic [7:0] wYear;
  logic [4:0] wMonth;
  logic [2:0] wDow;
  logic [5:0] wDate;
  logic centOk;
  logic yearOk;
  logic monthOk;
  logic dowOk;
  logic dateOk;
  logic allOk;
  logic dateLoad;
  logic step;
  logic leapYear;
  logic [5:0] monthLen;
  logic [5:0] dateNext;
  logic dateWrap;
  logic [4:0] monthNext;
  logic monthWrap;
  logic [7:0] yearNext;
  logic yearWrap;
  logic [2:0] dowNext;
  logic [31:0] wordNow;

  assign selDate = (addr == rcr_pkg::CAL_DATE_WORD_ADDR);
  assign selStat = (addr == rcr_pkg::CAL_STATUS_ADDR);
  assign selCtrl = (addr == rcr_pkg::CAL_CTRL_ADDR);

  // slice the written word into its fields
  assign wCent = wrData[rcr_pkg::CENTURY_FIELD_LSB +: rcr_pkg::CENTURY_FIELD_W];
  assign wYear = wrData[rcr_pkg::YEAR_LSB +: rcr_pkg::YEAR_W];
  assign wMonth = wrData[rcr_pkg::MONTH_LSB +: rcr_pkg::MONTH_W];
  assign wDow = wrData[rcr_pkg::DOW_LSB +: rcr_pkg::DOW_W];
  assign wDate = wrData[rcr_pkg::DATE_LSB +: rcr_pkg::DATE_W];

  // field checks
  assign centOk = (wCent == rcr_pkg::CENTURY_FIELD_ONLY);

  rcr_bcd_check #(
    .W(rcr_pkg::YEAR_W),
    .LO(rcr_pkg::YEAR_MIN),
    .HI(rcr_pkg::YEAR_MAX)
  ) uYearCheck (
    .value(wYear),
    .ok(yearOk)
  );

  rcr_bcd_check #(
    .W(rcr_pkg::MONTH_W),
    .LO(rcr_pkg::MONTH_MIN),
    .HI(rcr_pkg::MONTH_MAX)
  ) uMonthCheck (
    .value(wMonth),
    .ok(monthOk)
  );

  rcr_bcd_check #(
    .W(rcr_pkg::DATE_W),
    .LO(rcr_pkg::DATE_MIN),
    .HI(rcr_pkg::DATE_MAX)
  ) uDateCheck (
    .value(wDate),
    .ok(dateOk)
  );

  assign dowOk = (wDow >= rcr_pkg::DOW_MIN) && (wDow <= rcr_pkg::DOW_MAX);

  // a write with any illegal field leaves the date untouched
  assign allOk = centOk && yearOk && monthOk && dowOk && dateOk;
  assign dateLoad = wrStrobe && selDate && allOk;

  // a software load in the same cycle beats a day step
  assign step = dayTick && countEn_q && !dateLoad;

  // leap year: tens even and units 0/4/8, or tens odd and units 2/6
  always_comb begin
    if (year_q[4] == 1'b0) begin
      leapYear = (year_q[3:0] == 4'h0) || (year_q[3:0] == 4'h4) || (year_q[3:0] == 4'h8);
    end else begin
      leapYear = (year_q[3:0] == 4'h2) || (year_q[3:0] == 4'h6);
    end
  end

  // length of the current month
  always_comb begin
    unique case (month_q)
      5'h02: monthLen = leapYear ? rcr_pkg::LEN_FEB_LEAP : rcr_pkg::LEN_FEB;
      5'h04, 5'h06, 5'h09, 5'h11: monthLen = rcr_pkg::LEN_SHORT;
      default: monthLen = rcr_pkg::LEN_LONG;
    endcase
  end

  rcr_bcd_inc #(
    .W(rcr_pkg::DATE_W),
    .LO(rcr_pkg::DATE_MIN)
  ) uDateInc (
    .value(date_q),
    .limit(monthLen),
    .nextValue(dateNext),
    .wrap(dateWrap)
  );

  rcr_bcd_inc #(
    .W(rcr_pkg::MONTH_W),
    .LO(rcr_pkg::MONTH_MIN)
  ) uMonthInc (
    .value(month_q),
    .limit(rcr_pkg::MONTH_MAX),
    .nextValue(monthNext),
    .wrap(monthWrap)
  );

  rcr_bcd_inc #(
    .W(rcr_pkg::YEAR_W),
    .LO(rcr_pkg::YEAR_MIN)
  ) uYearInc (
    .value(year_q),
    .limit(rcr_pkg::YEAR_MAX),
    .nextValue(yearNext),
    .wrap(yearWrap)
  );

  // day of week rolls 7 to 1 and never feeds the date chain
  assign dowNext = (dow_q >= rcr_pkg::DOW_MAX) ? rcr_pkg::DOW_MIN : dow_q + 3'h1;

  // century is fixed to the only legal value
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      century_field_q <= rcr_pkg::CENTURY_FIELD_RST;
    end else if (dateLoad) begin
      century_field_q <= wCent;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      date_q <= rcr_pkg::DATE_RST;
    end else if (dateLoad) begin
      date_q <= wDate;
    end else if (step) begin
      date_q <= dateNext;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      month_q <= rcr_pkg::MONTH_RST;
    end else if (dateLoad) begin
      month_q <= wMonth;
    end else if (step && dateWrap) begin
      month_q <= monthNext;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      year_q <= rcr_pkg::YEAR_RST;
    end else if (dateLoad) begin
      year_q <= wYear;
    end else if (step && dateWrap && monthWrap) begin
      year_q <= yearNext;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dow_q <= rcr_pkg::DOW_RST;
    end else if (dateLoad) begin
      dow_q <= wDow;
    end else if (step) begin
      dow_q <= dowNext;
    end
  end

  // sticky flag for a rejected date write; write 1 clears, a new set wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      badWrite_q <= 1'b0;
    end else if (wrStrobe && selDate && !allOk) begin
      badWrite_q <= 1'b1;
    end else if (wrStrobe && selStat && wrData[rcr_pkg::STAT_BAD_WRITE_BIT]) begin
      badWrite_q <= 1'b0;
    end
  end

  // sticky flag for a year 99 to 00 rollover
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      yearWrap_q <= 1'b0;
    end else if (step && dateWrap && monthWrap && yearWrap) begin
      yearWrap_q <= 1'b1;
    end else if (wrStrobe && selStat && wrData[rcr_pkg::STAT_YEAR_WRAP_BIT]) begin
      yearWrap_q <= 1'b0;
    end
  end

  // counting enable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      countEn_q <= rcr_pkg::CTRL_COUNT_EN_RST;
    end else if (wrStrobe && selCtrl) begin
      countEn_q <= wrData[rcr_pkg::CTRL_COUNT_EN_BIT];
    end
  end

  // assemble the date word, spare bits zero
  always_comb begin
    wordNow = 32'h0;
    wordNow[rcr_pkg::CENTURY_FIELD_LSB +: rcr_pkg::CENTURY_FIELD_W] = century_field_q;
    wordNow[rcr_pkg::YEAR_LSB +: rcr_pkg::YEAR_W] = year_q;
    wordNow[rcr_pkg::MONTH_LSB +: rcr_pkg::MONTH_W] = month_q;
    wordNow[rcr_pkg::DOW_LSB +: rcr_pkg::DOW_W] = dow_q;
    wordNow[rcr_pkg::DATE_LSB +: rcr_pkg::DATE_W] = date_q;
  end

  assign dateWord = wordNow;

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 32'h0;
    end else if (rdStrobe) begin
      if (selDate) begin
        rdData_q <= wordNow;
      end else if (selStat) begin
        rdData_q <= {30'h0, yearWrap_q, badWrite_q};
      end else if (selCtrl) begin
        rdData_q <= {31'h0, countEn_q};
      end else begin
        rdData_q <= 32'h0;
      end
    end else begin
      rdData_q <= 32'h0;
    end
  end

  assign rdData = rdData_q;
endmodule

//--- rcr_calendar_register_assertions.sv
module rcr_calendar_register_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [31:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [31:0] rdData,
  input wire logic dayTick,
  input wire logic [31:0] dateWord
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  function automatic logic legal(logic [31:0] w);
    return w[6:0] == 7'h20 && w[11:8] <= 4'h9 && w[15:12] <= 4'h9
      && w[20:16] >= 5'h01 && w[20:16] <= 5'h12 && w[19:16] <= 4'h9 && w[23:21] != 3'h0
      && w[29:24] >= 6'h01 && w[29:24] <= 6'h31 && w[27:24] <= 4'h9;
  endfunction
  wire logic hitDate = addr == rcr_pkg::CAL_DATE_WORD_ADDR;
  sequence legalWr;
    wrStrobe && hitDate && legal(wrData);
  endsequence
  sequence badWr;
    wrStrobe && hitDate && !legal(wrData) && !dayTick;
  endsequence
  sequence dateRd;
    rdStrobe && hitDate;
  endsequence
  AST_CENTURY_FIELD: assert property (dateWord[6:0] == 7'h20)
    else $error("century field not twenty");
  AST_YEAR: assert property (dateWord[11:8] <= 4'h9 && dateWord[15:12] <= 4'h9)
    else $error("year field not bcd");
  AST_MONTH: assert property (dateWord[20:16] >= 5'h01 && dateWord[20:16] <= 5'h12)
    else $error("month field out of range");
  AST_DATE: assert property (dateWord[29:24] >= 6'h01 && dateWord[29:24] <= 6'h31)
    else $error("day of month out of range");
  AST_DOW: assert property (dateWord[23:21] != 3'h0)
    else $error("day of week zero");
  AST_SPARE: assert property (dateWord[31:30] == 2'h0 && dateWord[7] == 1'b0)
    else $error("spare bits not zero");
  AST_WRITE: assert property (legalWr |=> dateWord == ($past(wrData) & 32'h3fffff7f))
    else $error("legal write not loaded");
  AST_REFUSE: assert property (badWr |=> $stable(dateWord))
    else $error("illegal write changed the date");
  AST_READ: assert property (dateRd |=> rdData == $past(dateWord))
    else $error("read data differs from date word");
  AST_RDIDLE: assert property (!rdStrobe |=> rdData == 32'h0)
    else $error("read data not zero outside read");
endmodule

//--- rcr_calendar_register_tb.sv
`define CHK(n, e, g) begin nChecks++; if ((g) !== (e)) begin nErrors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module rcr_calendar_register_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] DA = rcr_pkg::CAL_DATE_WORD_ADDR;
  localparam logic [31:0] ST = rcr_pkg::CAL_STATUS_ADDR;
  localparam logic [31:0] CT = rcr_pkg::CAL_CTRL_ADDR;
  localparam logic [32:0] ROWS [11] = '{{1'b1, 32'h15434920}, {1'b1, 32'h31f29920},
    {1'b0, 32'h31f29921}, {1'b0, 32'h31f39920}, {1'b0, 32'h31e09920}, {1'b0, 32'h32f29920},
    {1'b0, 32'h00f29920}, {1'b0, 32'h31129920}, {1'b0, 32'h1af29920}, {1'b0, 32'h31f29a20},
    {1'b1, 32'hc12100a0}};
  localparam logic [31:0] TICKS [5][2] = '{'{32'h30692320, 32'h01902320},
    '{32'h19a12320, 32'h20c12320}, '{32'h28222320, 32'h01432320},
    '{32'h28222420, 32'h29422420}, '{32'h31f29920, 32'h01210020}};
  logic refClk, arstN, wrStrobe, rdStrobe, dayTick;
  logic [31:0] addr, wrData, rdData, dateWord, got, prev;
  int nErrors = 0;
  int nChecks = 0;
  rcr_calendar_register rcr_calendar_register_inst (.ref_clk(refClk), .arst_n(arstN),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .dayTick(dayTick), .dateWord(dateWord));
  initial begin
    refClk = 1'b0;
    forever #5 refClk = ~refClk;
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge refClk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge refClk);
    wrStrobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge refClk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge refClk);
    rdStrobe <= 1'b0;
    #1 got = rdData;
  endtask
  task automatic tick;
    @(posedge refClk);
    dayTick <= 1'b1;
    @(posedge refClk);
    dayTick <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #900us;
    nErrors++;
    tally_and_finish;
  end
  initial begin
    addr = 32'h0;
    wrData = 32'h0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    dayTick = 1'b0;
    arstN = 1'b0;
    repeat (4) @(posedge refClk);
    arstN <= 1'b1;
    #1 `CHK("reset word", 32'h01210020, dateWord)
    `CHK("reset read", 32'h0, rdData)
    rd(ST);
    `CHK("reset status", 32'h0, got)
    rd(CT);
    `CHK("reset control", 32'h1, got)
    $display("reset test done");
    prev = 32'h01210020;
    for (int i = 0; i < 11; i++) begin
      wr(DA, ROWS[i][31:0]);
      if (ROWS[i][32]) prev = ROWS[i][31:0] & 32'h3fffff7f;
      `CHK("date word", prev, dateWord)
      rd(DA);
      `CHK("date read", prev, got)
    end
    $display("table test done");
    rd(ST);
    `CHK("refused flag", 1'b1, got[0])
    wr(ST, 32'h1);
    rd(32'hfffffec8);
    `CHK("unmapped read", 32'h0, got)
    for (int i = 0; i < 5; i++) begin
      wr(DA, TICKS[i][0]);
      tick;
      `CHK("after tick", TICKS[i][1], dateWord)
    end
    rd(ST);
    `CHK("status", 32'h2, got)
    wr(ST, 32'h2);
    rd(ST);
    `CHK("status cleared", 32'h0, got)
    wr(DA, 32'h31f29920);
    @(posedge refClk);
    addr <= ST;
    wrData <= 32'h2;
    wrStrobe <= 1'b1;
    dayTick <= 1'b1;
    @(posedge refClk);
    wrStrobe <= 1'b0;
    dayTick <= 1'b0;
    rd(ST);
    `CHK("wrap beats clear", 32'h2, got)
    $display("tick test done");
    wr(CT, 32'h0);
    rd(CT);
    `CHK("control off", 32'h0, got)
    tick;
    `CHK("halted tick", 32'h01210020, dateWord)
    wr(CT, 32'h1);
    @(posedge refClk);
    addr <= DA;
    wrData <= 32'h15434920;
    wrStrobe <= 1'b1;
    dayTick <= 1'b1;
    @(posedge refClk);
    wrStrobe <= 1'b0;
    dayTick <= 1'b0;
    #1 `CHK("write beats tick", 32'h15434920, dateWord)
    tick;
    `CHK("tick re-enabled", 32'h16634920, dateWord)
    $display("awkward test done");
    @(posedge refClk);
    arstN <= 1'b0;
    @(posedge refClk);
    arstN <= 1'b1;
    #1 `CHK("second reset word", 32'h01210020, dateWord)
    rd(ST);
    `CHK("second reset status", 32'h0, got)
    $display("second reset test done");
    tally_and_finish;
  end
endmodule
bind rcr_calendar_register rcr_calendar_register_checker rcr_calendar_register_checker_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
  .rdStrobe(rdStrobe), .rdData(rdData), .dayTick(dayTick), .dateWord(dateWord));
